/* hw/umsl_defines.svh */
`ifndef UMSL_DEFINES_SVH
`define UMSL_DEFINES_SVH

// Register byte offsets on the Avalon-MM slave
`define UMSL_OFS_MODEM_CTRL 5'h00
`define UMSL_OFS_MODEM_STAT 5'h04
`define UMSL_OFS_ISR 5'h08
`define UMSL_OFS_IMR 5'h0C
`define UMSL_OFS_DIV 5'h10
`define UMSL_OFS_TXD 5'h14
`define UMSL_OFS_RXD 5'h18

// Modem control field positions
`define UMSL_CTRL_RTS 1
`define UMSL_CTRL_LOOP 4
// Modem status field positions
`define UMSL_STAT_EDGE 2
`define UMSL_STAT_RING 6
// Interrupt status / mask field positions
`define UMSL_IRQ_MODEM 0
`define UMSL_IRQ_RXDONE 1
`define UMSL_IRQ_TXDONE 2
// Receive data word: valid flag position
`define UMSL_RXD_VALID 8
// Transmit data word: busy flag position
`define UMSL_TXD_BUSY 0

// Reset values
`define UMSL_CTRL_RST 8'h00
`define UMSL_IMR_RST 3'h0
`define UMSL_LINE_MARK 1'b1
`define UMSL_RING_IDLE 1'b1

// Line timing
`define UMSL_CLK_HZ 50000000
`define UMSL_BAUD 9600
`define UMSL_DATA_BITS 3'h7
`define UMSL_DIV_W 16

`endif

/* hw/umsl_pkg.sv */
`default_nettype none
package umsl_pkg;
  // One Avalon-MM request as seen by the slave
  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
  } umsl_av_req_t;

  // Events that can raise the interrupt
  typedef struct packed {
    logic txDone;
    logic rxDone;
    logic modem;
  } umsl_irq_t;

  // Serial frame sequencer states, shared by transmitter and receiver
  typedef enum logic [1:0] {
    UMSL_IDLE = 2'b00,
    UMSL_START = 2'b01,
    UMSL_DATA = 2'b10,
    UMSL_STOP = 2'b11
  } umsl_state_t;
endpackage
`default_nettype wire

/* hw/umsl_modem_signal.sv */
// Behaviour
// - ring input is active low; low means the modem hears a ring.
// - modem status bit 6 reads as the inverse of the ring input.
// - modem status bit 2 sets on ring low-to-high since last status read; here an interrupt status read clears it too.
// - ring trailing-edge flag with modem-status interrupt enabled raises the interrupt.
// - modem control bit 1 high drives request-to-send low; zero returns it high.
// - reset forces request-to-send high, inactive.
// - loopback mode holds request-to-send inactive whatever the control bit says.
// - serial data from the line is accepted on the serial input pin.
// - after reset the serial output sits at marking level, logic 1.
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`include "umsl_defines.svh"
`default_nettype none
module umsl_modem_signal
  import umsl_pkg::*;
#(
  parameter int BIT_CYCLES = `UMSL_CLK_HZ / `UMSL_BAUD
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Avalon-MM slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Modem and line pins
  input wire logic ringInd_n,
  input wire logic serialIn,
  output logic rts_n,
  output logic serialOut,
  // Interrupt
  output logic irq
);

  localparam logic [`UMSL_DIV_W-1:0] DIV_RST = BIT_CYCLES[`UMSL_DIV_W-1:0];

  // True on the last cycle of one bit period
  function automatic logic bitEnd(input logic [`UMSL_DIV_W-1:0] cnt,
                                  input logic [`UMSL_DIV_W-1:0] div);
    bitEnd = (cnt >= div - `UMSL_DIV_W'h1);
  endfunction

  // Zero-extend an interrupt group to a bus word
  function automatic logic [31:0] irqWord(input umsl_irq_t v);
    irqWord = {29'h0, v};
  endfunction

  umsl_av_req_t req;
  logic ackR_r;
  logic doWrite;
  logic doRead;
  logic [7:0] modemCtrl_r;
  logic [2:0] imr_r;
  logic [`UMSL_DIV_W-1:0] div_r;
  logic ringPrev_r;
  logic ringEdgeSet;
  umsl_irq_t isr_r;
  logic rdModemStat;
  logic rdIsr;
  logic loopMode;
  // Transmitter
  umsl_state_t txState_r;
  logic [`UMSL_DIV_W-1:0] txCnt_r;
  logic [2:0] txBit_r;
  logic [7:0] txShift_r;
  logic txLine_r;
  logic txStart;
  logic txDoneEv;
  // Receiver
  umsl_state_t rxState_r;
  logic [`UMSL_DIV_W-1:0] rxCnt_r;
  logic [2:0] rxBit_r;
  logic [7:0] rxShift_r;
  logic [7:0] rxData_r;
  logic rxValid_r;
  logic rxDoneEv;
  logic rxLine;
  logic rdRxd;

  // Gather the bus request into one carrier
  assign req.read = read;
  assign req.write = write;
  assign req.address = address;
  assign req.writedata = writedata;

  // One wait state: the answer is taken at the second edge of a request
  assign waitrequest = (req.read | req.write) & ~ackR_r;
  assign doWrite = req.write & ackR_r;
  assign doRead = req.read & ackR_r;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ackR_r <= 1'b0;
    end else begin
      ackR_r <= (req.read | req.write) & ~ackR_r;
    end
  end

  // Read data captured in the wait cycle, held through the answer edge
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      readdata <= 32'h0;
    end else if (req.read && !ackR_r) begin
      unique case (req.address)
        `UMSL_OFS_MODEM_CTRL: readdata <= {24'h0, modemCtrl_r};
        `UMSL_OFS_MODEM_STAT: begin
          readdata <= 32'h0;
          readdata[`UMSL_STAT_RING] <= ~ringInd_n;
          readdata[`UMSL_STAT_EDGE] <= isr_r.modem;
        end
        `UMSL_OFS_ISR: readdata <= irqWord(isr_r);
        `UMSL_OFS_IMR: readdata <= irqWord(imr_r);
        `UMSL_OFS_DIV: readdata <= {16'h0, div_r};
        `UMSL_OFS_TXD: begin
          readdata <= 32'h0;
          readdata[`UMSL_TXD_BUSY] <= (txState_r != UMSL_IDLE);
        end
        `UMSL_OFS_RXD: readdata <= {23'h0, rxValid_r, rxData_r};
        default: readdata <= 32'h0; // Unmapped reads as zero
      endcase
    end
  end

  // Modem control register; loopback lives in bit 4
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      modemCtrl_r <= `UMSL_CTRL_RST;
    end else if (doWrite && req.address == `UMSL_OFS_MODEM_CTRL) begin
      modemCtrl_r <= req.writedata[7:0];
    end
  end

  // Interrupt mask
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      imr_r <= `UMSL_IMR_RST;
    end else if (doWrite && req.address == `UMSL_OFS_IMR) begin
      imr_r <= req.writedata[2:0];
    end
  end

  // Bit period in clock cycles; zero would stall, so it is clamped to one
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_r <= DIV_RST;
    end else if (doWrite && req.address == `UMSL_OFS_DIV) begin
      div_r <= (req.writedata[15:0] == 16'h0) ? 16'h1 : req.writedata[15:0];
    end
  end

  assign loopMode = modemCtrl_r[`UMSL_CTRL_LOOP];

  // Ring input is active low, so its trailing edge is a rise
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ringPrev_r <= `UMSL_RING_IDLE;
    end else begin
      ringPrev_r <= ringInd_n;
    end
  end
  assign ringEdgeSet = ~ringPrev_r & ringInd_n;

  // Sticky events; a read clears only the bits its captured word carried,
  // so an event landing between capture and answer is not lost; a set wins
  assign rdModemStat = doRead && req.address == `UMSL_OFS_MODEM_STAT;
  assign rdIsr = doRead && req.address == `UMSL_OFS_ISR;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      isr_r <= '0;
    end else begin
      isr_r.modem <= ringEdgeSet | (isr_r.modem
        & ~(rdModemStat & readdata[`UMSL_STAT_EDGE])
        & ~(rdIsr & readdata[`UMSL_IRQ_MODEM]));
      isr_r.rxDone <= rxDoneEv | (isr_r.rxDone & ~(rdIsr & readdata[`UMSL_IRQ_RXDONE]));
      isr_r.txDone <= txDoneEv | (isr_r.txDone & ~(rdIsr & readdata[`UMSL_IRQ_TXDONE]));
    end
  end

  // Level interrupt; mask bit 0 is the modem-status enable
  assign irq = |(isr_r & imr_r);

  // Request-to-send; reset and loopback both keep it high
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rts_n <= 1'b1;
    end else begin
      rts_n <= ~(modemCtrl_r[`UMSL_CTRL_RTS] & ~loopMode);
    end
  end

  // Transmitter: 8 data bits, no parity, one stop bit
  assign txStart = doWrite && req.address == `UMSL_OFS_TXD && txState_r == UMSL_IDLE;
  assign txDoneEv = txState_r == UMSL_STOP && bitEnd(txCnt_r, div_r);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      txState_r <= UMSL_IDLE;
      txCnt_r <= '0;
      txBit_r <= 3'h0;
      txShift_r <= 8'h00;
      txLine_r <= `UMSL_LINE_MARK;
    end else begin
      txCnt_r <= bitEnd(txCnt_r, div_r) ? '0 : txCnt_r + `UMSL_DIV_W'h1;
      unique case (txState_r)
        UMSL_IDLE: begin
          txCnt_r <= '0;
          txLine_r <= `UMSL_LINE_MARK;
          if (txStart) begin
            txShift_r <= req.writedata[7:0];
            txLine_r <= 1'b0;
            txState_r <= UMSL_START;
          end
        end
        UMSL_START: begin
          if (bitEnd(txCnt_r, div_r)) begin
            txLine_r <= txShift_r[0];
            txBit_r <= 3'h0;
            txState_r <= UMSL_DATA;
          end
        end
        UMSL_DATA: begin
          if (bitEnd(txCnt_r, div_r)) begin
            if (txBit_r == `UMSL_DATA_BITS) begin
              txLine_r <= `UMSL_LINE_MARK;
              txState_r <= UMSL_STOP;
            end else begin
              txShift_r <= {1'b0, txShift_r[7:1]};
              txLine_r <= txShift_r[1];
              txBit_r <= txBit_r + 3'h1;
            end
          end
        end
        UMSL_STOP: begin
          if (bitEnd(txCnt_r, div_r)) begin
            txState_r <= UMSL_IDLE;
          end
        end
      endcase
    end
  end

  // Pin stays marking in loopback; the frame goes to the receiver instead
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      serialOut <= `UMSL_LINE_MARK;
    end else begin
      serialOut <= loopMode ? `UMSL_LINE_MARK : txLine_r;
    end
  end

  // Receiver source: the line pin, or the transmitter in loopback
  assign rxLine = loopMode ? txLine_r : serialIn;
  assign rxDoneEv = rxState_r == UMSL_STOP && bitEnd(rxCnt_r, div_r) && rxLine;
  assign rdRxd = doRead && req.address == `UMSL_OFS_RXD;

  // Receiver samples each bit at its middle; a low stop bit drops the frame
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxState_r <= UMSL_IDLE;
      rxCnt_r <= '0;
      rxBit_r <= 3'h0;
      rxShift_r <= 8'h00;
    end else begin
      rxCnt_r <= bitEnd(rxCnt_r, div_r) ? '0 : rxCnt_r + `UMSL_DIV_W'h1;
      unique case (rxState_r)
        UMSL_IDLE: begin
          // Start half a period in, so later samples land mid-bit
          rxCnt_r <= div_r >> 1;
          if (!rxLine) begin
            rxState_r <= UMSL_START;
          end
        end
        UMSL_START: begin
          if (bitEnd(rxCnt_r, div_r)) begin
            rxBit_r <= 3'h0;
            rxState_r <= rxLine ? UMSL_IDLE : UMSL_DATA; // Glitch rejected
          end
        end
        UMSL_DATA: begin
          if (bitEnd(rxCnt_r, div_r)) begin
            rxShift_r <= {rxLine, rxShift_r[7:1]};
            rxBit_r <= rxBit_r + 3'h1;
            if (rxBit_r == `UMSL_DATA_BITS) begin
              rxState_r <= UMSL_STOP;
            end
          end
        end
        UMSL_STOP: begin
          if (bitEnd(rxCnt_r, div_r)) begin
            rxState_r <= UMSL_IDLE;
          end
        end
      endcase
    end
  end

  // Received byte; an unread byte is overwritten by the next frame
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxData_r <= 8'h00;
      rxValid_r <= 1'b0;
    end else begin
      if (rxDoneEv) begin
        rxData_r <= rxShift_r;
      end
      rxValid_r <= rxDoneEv | (rxValid_r & ~(rdRxd & readdata[`UMSL_RXD_VALID]));
    end
  end

endmodule // umsl_modem_signal
`default_nettype wire

/* testbench/umsl_modem_signal_assertions.sv */
`include "umsl_defines.svh"
`default_nettype none
module umsl_modem_signal_assertions #(
  parameter int BIT_CYCLES = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Avalon-MM slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Modem and line pins
  input wire logic ringInd_n,
  input wire logic serialIn,
  input wire logic rts_n,
  input wire logic serialOut,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic [2:0] maskR;
  logic rtsExp;
  logic statAck;
  logic ctrlAck;
  logic reqOn;
  // Answer edges of the registers watched here
  assign statAck = read && !waitrequest && address == `UMSL_OFS_MODEM_STAT;
  assign ctrlAck = write && !waitrequest && address == `UMSL_OFS_MODEM_CTRL;
  assign reqOn = read || write;
  // Shadow of mask and expected pin, taken from host writes only
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      maskR <= 3'h0;
      rtsExp <= 1'b1;
    end else begin
      if (write && !waitrequest && address == `UMSL_OFS_IMR) maskR <= writedata[2:0];
      if (ctrlAck) rtsExp <= !(writedata[`UMSL_CTRL_RTS] && !writedata[`UMSL_CTRL_LOOP]);
    end
  end
  rts_reset_a: assert property ($rose(arst_n) |-> rts_n)
    else $error("rts_n low after reset");
  line_mark_a: assert property ($rose(arst_n) |-> serialOut)
    else $error("serialOut not marking after reset");
  rts_write_a: assert property ($past(ctrlAck, 2) |-> rts_n == rtsExp)
    else $error("rts_n does not follow control write");
  rts_hold_a: assert property (!ctrlAck && !$past(ctrlAck) |=> $stable(rts_n))
    else $error("rts_n moved without control write");
  ring_status_a: assert property (statAck |-> readdata[6] == !$past(ringInd_n))
    else $error("ring status bit wrong");
  ring_irq_a: assert property ($rose(ringInd_n) && maskR[0] |-> ##[1:2] irq)
    else $error("ring release raised no interrupt");
  irq_masked_a: assert property (maskR == 3'h0 |-> !irq)
    else $error("interrupt while all masked");
  stat_clear_a: assert property (statAck && maskR == 3'h1 && ringInd_n && $past(ringInd_n)
    && $past(ringInd_n, 2) |=> !irq)
    else $error("status read left flag set");
  wait_state_a: assert property (reqOn && !$past(reqOn) |-> waitrequest ##1 !waitrequest)
    else $error("bus answer not after one wait state");
  ring_rise_c: cover property ($rose(ringInd_n));
  ctrl_write_c: cover property (ctrlAck);
  stat_read_c: cover property (statAck);
  irq_raise_c: cover property ($rose(irq));
endmodule // umsl_modem_signal_assertions
bind umsl_modem_signal umsl_modem_signal_assertions #(.BIT_CYCLES(BIT_CYCLES)) chk_inst (
  .sys_clk(sys_clk), .arst_n(arst_n), .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .ringInd_n(ringInd_n), .serialIn(serialIn), .rts_n(rts_n), .serialOut(serialOut), .irq(irq));
`default_nettype wire

/* testbench/umsl_modem_model.sv */
`default_nettype none
module umsl_modem_model (
  // Bench control
  input wire logic ringReq,
  // Line pins
  input wire logic rts_n,
  input wire logic serialOut,
  output logic ringInd_n,
  output logic serialIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // Ring drawn low on request; echo only while asked to send, else marking
  assign ringInd_n = !ringReq;
  assign serialIn = rts_n ? 1'b1 : serialOut;
endmodule // umsl_modem_model
`default_nettype wire

/* testbench/test_umsl_modem_signal.sv */
`include "umsl_defines.svh"
`default_nettype none
module test_umsl_modem_signal;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, arst_n, read, write, ringReq;
  logic [4:0] address;
  logic [31:0] writedata, rd;
  wire logic [31:0] readdata;
  wire logic waitrequest, ringInd_n, serialIn, rts_n, serialOut, irq;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  umsl_modem_signal #(.BIT_CYCLES(8)) umsl_modem_signal_inst (.sys_clk(sys_clk),
    .arst_n(arst_n), .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .ringInd_n(ringInd_n),
    .serialIn(serialIn), .rts_n(rts_n), .serialOut(serialOut), .irq(irq));
  umsl_modem_model umsl_modem_model_inst (.ringReq(ringReq), .rts_n(rts_n),
    .serialOut(serialOut), .ringInd_n(ringInd_n), .serialIn(serialIn));
  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test;
    if (miscompares == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One bus cycle; extra edge after release so strobes never flip twice at once
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do @(posedge sys_clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic test_reset;
    check("rts_n", rts_n, 32'h1);
    check("serialOut", serialOut, 32'h1);
    check("irq", irq, 32'h0);
    check("readdata", readdata, 32'h0);
    check("waitrequest", waitrequest, 32'h0);
  endtask
  // Divisor and mask registers: reset values, zero clamp, restore
  task automatic test_divisor;
    bus(1'b0, `UMSL_OFS_DIV, 32'h0);
    check("div reset", rd, 32'h8);
    bus(1'b1, `UMSL_OFS_DIV, 32'h0);
    bus(1'b0, `UMSL_OFS_DIV, 32'h0);
    check("div clamp", rd, 32'h1);
    bus(1'b1, `UMSL_OFS_DIV, 32'h8);
    bus(1'b0, `UMSL_OFS_IMR, 32'h0);
    check("mask reset", rd, 32'h0);
  endtask
  task automatic test_rts;
    bus(1'b1, `UMSL_OFS_MODEM_CTRL, 32'h2);
    @(posedge sys_clk);
    check("rts on", rts_n, 32'h0);
    bus(1'b1, `UMSL_OFS_MODEM_CTRL, 32'h12);
    @(posedge sys_clk);
    check("rts loop", rts_n, 32'h1);
    bus(1'b0, `UMSL_OFS_MODEM_CTRL, 32'h0);
    check("ctrl readback", rd, 32'h12);
    bus(1'b1, `UMSL_OFS_MODEM_CTRL, 32'h2);
    @(posedge sys_clk);
    check("rts loop exit", rts_n, 32'h0);
    bus(1'b1, `UMSL_OFS_MODEM_CTRL, 32'h0);
    @(posedge sys_clk);
    check("rts off", rts_n, 32'h1);
    bus(1'b0, 5'h1C, 32'h0);
    check("unmapped", rd, 32'h0);
  endtask
  // Ring held low for three cycles, then released
  task automatic ring_pulse;
    ringReq <= 1'b1;
    repeat (3) @(posedge sys_clk);
    ringReq <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic test_ring;
    ringReq <= 1'b1;
    repeat (3) @(posedge sys_clk);
    bus(1'b0, `UMSL_OFS_MODEM_STAT, 32'h0);
    check("ring low", rd & 32'h44, 32'h40);
    ringReq <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check("irq masked", irq, 32'h0);
    bus(1'b0, `UMSL_OFS_MODEM_STAT, 32'h0);
    check("ring rose", rd & 32'h44, 32'h04);
    bus(1'b0, `UMSL_OFS_MODEM_STAT, 32'h0);
    check("flag clear", rd & 32'h44, 32'h0);
    bus(1'b1, `UMSL_OFS_IMR, 32'h1);
    ring_pulse();
    check("irq on", irq, 32'h1);
    bus(1'b0, `UMSL_OFS_MODEM_STAT, 32'h0);
    check("status flag", rd & 32'h44, 32'h04);
    check("irq cleared", irq, 32'h0);
    ring_pulse();
    check("irq again", irq, 32'h1);
    bus(1'b0, `UMSL_OFS_ISR, 32'h0);
    check("isr modem", rd, 32'h1);
    check("irq off", irq, 32'h0);
    bus(1'b1, `UMSL_OFS_IMR, 32'h0);
  endtask
  // Modem echoes only while asked to send, so the byte needs rts active
  task automatic test_serial;
    bus(1'b1, `UMSL_OFS_MODEM_CTRL, 32'h2);
    bus(1'b1, `UMSL_OFS_TXD, 32'hA5);
    bus(1'b0, `UMSL_OFS_TXD, 32'h0);
    check("tx busy", rd, 32'h1);
    do bus(1'b0, `UMSL_OFS_RXD, 32'h0); while (rd[8] !== 1'b1);
    check("rx byte", rd[8:0], 32'h1A5);
    do bus(1'b0, `UMSL_OFS_TXD, 32'h0); while (rd[0] !== 1'b0);
    // Loopback: frame returns inside while the pin stays marking
    bus(1'b1, `UMSL_OFS_MODEM_CTRL, 32'h10);
    bus(1'b1, `UMSL_OFS_TXD, 32'h3C);
    @(posedge sys_clk);
    check("loop pin", serialOut, 32'h1);
    do bus(1'b0, `UMSL_OFS_RXD, 32'h0); while (rd[8] !== 1'b1);
    check("loop byte", rd[8:0], 32'h13C);
    do bus(1'b0, `UMSL_OFS_TXD, 32'h0); while (rd[0] !== 1'b0);
    bus(1'b0, `UMSL_OFS_ISR, 32'h0);
    check("isr frames", rd, 32'h6);
    bus(1'b1, `UMSL_OFS_MODEM_CTRL, 32'h0);
  endtask
  // Main sequence
  initial begin
    arst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0;
    ringReq = 1'b0;
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    test_reset();
    test_divisor();
    test_rts();
    test_ring();
    test_serial();
    finish_test();
  end
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      finish_test();
    end
  end
endmodule // test_umsl_modem_signal
`default_nettype wire
